// ### include/fsp_pkg.sv
// constants and types for the flash sector protection block
package fsp_pkg;
  localparam int          BUS_AW        = 8;
  localparam int          FLASH_AW      = 16;
  localparam logic [7:0]  ADDR_PROTECT  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [15:0] NV_PROT_ADDR  = 16'hFF0D;
  localparam int          BIT_POL       = 7;
  localparam int          BIT_SPARE     = 6;
  localparam int          BIT_HDIS      = 5;
  localparam int          BIT_HS_LO     = 3;
  localparam int          BIT_LDIS      = 2;
  localparam int          BIT_LS_LO     = 0;
  localparam int          BIT_VIOL      = 5;
  localparam logic [7:0]  PROT_PRELOAD  = 8'h24;
  localparam logic [15:0] LOW_START     = 16'h4000;
  localparam logic [15:0] HIGH_START_0  = 16'hF800;
  localparam logic [15:0] HIGH_START_1  = 16'hF000;
  localparam logic [15:0] HIGH_START_2  = 16'hE000;
  localparam logic [15:0] HIGH_START_3  = 16'hC000;
  localparam logic [15:0] LOW_END_0     = 16'h41FF;
  localparam logic [15:0] LOW_END_1     = 16'h43FF;
  localparam logic [15:0] LOW_END_2     = 16'h47FF;
  localparam logic [15:0] LOW_END_3     = 16'h4FFF;
  // allowed targets per source scenario {pol,hdis,ldis}, bit n = target n
  localparam logic [63:0] SCEN_ALLOWED  = 64'hFF5A3C18080C0A0F;

  typedef enum logic [1:0] {
    FSP_CMD_PROGRAM = 2'h0,
    FSP_CMD_ERASE   = 2'h1,
    FSP_CMD_MASS    = 2'h2
  } fsp_kind_t;

  typedef struct packed {
    fsp_kind_t             kind;
    logic [FLASH_AW-1:0]   addr;
  } fsp_cmd_t;

  typedef struct packed {
    logic       pol;
    logic       spare;
    logic       hdis;
    logic [1:0] hsize;
    logic       ldis;
    logic [1:0] lsize;
  } fsp_prot_t;

  typedef enum logic [1:0] {
    FSP_ST_LOAD = 2'b01,
    FSP_ST_RUN  = 2'b10
  } fsp_state_t;
endpackage

// ### core/fsp_flash_protect.sv
// protection register, range decode and command screening
`default_nettype none
module fsp_flash_protect
  import fsp_pkg::*;
#(
  parameter int FLASH_W = FLASH_AW
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // register port
  input  wire logic [BUS_AW-1:0]  reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  // nonvolatile byte from the array
  input  wire logic [7:0]         nv_prot_byte,
  // command request
  input  wire logic               cmd_valid,
  input  wire fsp_cmd_t           cmd_in,
  output logic                    cmd_ready,
  // command result
  output logic                    cmd_launch,
  output logic                    cmd_reject,
  output fsp_cmd_t                cmd_out,
  output logic                    protect_violation_flag
);

  if (FLASH_W != FLASH_AW) begin : g_chk
    $error("flash address width must be 16");
  end

  fsp_state_t state;
  fsp_prot_t  prot;
  fsp_prot_t  next_prot;
  logic       wr_prot;
  logic       wr_stat;
  logic       write_ok;
  logic       take;
  logic       blocked;
  logic [2:0] scen_old;
  logic [2:0] scen_new;
  logic [15:0] high_start;
  logic [15:0] low_end;
  logic       in_high;
  logic       in_low;
  logic       hit;
  logic       is_protected;
  logic       all_open;

  // reset load sequence
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= FSP_ST_LOAD;
    end else begin
      unique case (state)
        FSP_ST_LOAD: state <= FSP_ST_RUN;
        FSP_ST_RUN:  state <= FSP_ST_RUN;
        default:     state <= FSP_ST_LOAD;
      endcase
    end
  end

  assign wr_prot = reg_wr && (reg_addr == ADDR_PROTECT);
  assign wr_stat = reg_wr && (reg_addr == ADDR_STATUS);

  // candidate value of a write, field by field
  always_comb begin
    next_prot       = prot;
    next_prot.pol   = prot.pol & reg_wdata[BIT_POL];
    next_prot.hdis  = reg_wdata[BIT_HDIS];
    next_prot.ldis  = reg_wdata[BIT_LDIS];
    if (prot.hdis) begin
      next_prot.hsize = reg_wdata[BIT_HS_LO +: 2];
    end
    if (prot.ldis) begin
      next_prot.lsize = reg_wdata[BIT_LS_LO +: 2];
    end
  end

  assign scen_old = {prot.pol, prot.hdis, prot.ldis};
  // judge the scenario the write asks for, not the masked one
  assign scen_new = {reg_wdata[BIT_POL], reg_wdata[BIT_HDIS], reg_wdata[BIT_LDIS]};
  assign write_ok = SCEN_ALLOWED[{scen_old, scen_new}];

  // protection register
  always_ff @(posedge clk) begin
    if (srst) begin
      prot <= PROT_PRELOAD;
    end else if (state == FSP_ST_LOAD) begin
      prot <= nv_prot_byte;
    end else if (wr_prot && write_ok) begin
      prot <= next_prot;
    end
  end

  // range decode
  always_comb begin
    unique case (prot.hsize)
      2'h0: high_start = HIGH_START_0;
      2'h1: high_start = HIGH_START_1;
      2'h2: high_start = HIGH_START_2;
      2'h3: high_start = HIGH_START_3;
    endcase
    unique case (prot.lsize)
      2'h0: low_end = LOW_END_0;
      2'h1: low_end = LOW_END_1;
      2'h2: low_end = LOW_END_2;
      2'h3: low_end = LOW_END_3;
    endcase
  end

  assign in_high = cmd_in.addr >= high_start;
  assign in_low  = (cmd_in.addr >= LOW_START) && (cmd_in.addr <= low_end);
  assign hit     = (!prot.hdis && in_high) || (!prot.ldis && in_low);
  // polarity one protects hits, polarity zero protects all but hits
  assign is_protected = prot.pol ? hit : !hit;
  assign all_open     = prot.pol && prot.hdis && prot.ldis;

  // command screening at launch
  assign cmd_ready = (state == FSP_ST_RUN) && !protect_violation_flag;
  assign take      = cmd_valid && cmd_ready;
  assign blocked   = (cmd_in.kind == FSP_CMD_MASS) ? !all_open : is_protected;

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_launch <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cmd_launch <= take && !blocked;
      cmd_reject <= take && blocked;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_out <= '0;
    end else if (take) begin
      cmd_out <= cmd_in;
    end
  end

  // violation flag, set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      protect_violation_flag <= 1'b0;
    end else if (take && blocked) begin
      protect_violation_flag <= 1'b1;
    end else if (wr_stat && reg_wdata[BIT_VIOL]) begin
      protect_violation_flag <= 1'b0;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == ADDR_PROTECT) begin
      reg_rdata <= prot;
    end else if (reg_rd && reg_addr == ADDR_STATUS) begin
      reg_rdata <= 8'(protect_violation_flag) << BIT_VIOL;
    end else begin
      reg_rdata <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_pol_never_sets;
    (state == FSP_ST_RUN) && ($past(state) == FSP_ST_RUN) && !$past(prot.pol) |-> !prot.pol;
  endproperty
  a_pol_never_sets: assert property (p_pol_never_sets) else $error("polarity bit set by write");

  property p_lsize_frozen;
    (state == FSP_ST_RUN) && !prot.ldis |=> $stable(prot.lsize);
  endproperty
  a_lsize_frozen: assert property (p_lsize_frozen) else $error("low size changed while enabled");

  property p_hsize_frozen;
    (state == FSP_ST_RUN) && !prot.hdis |=> $stable(prot.hsize);
  endproperty
  a_hsize_frozen: assert property (p_hsize_frozen) else $error("high size changed while enabled");

  property p_reset_load;
    (state == FSP_ST_LOAD) |=> (prot == $past(nv_prot_byte)) && (state == FSP_ST_RUN);
  endproperty
  a_reset_load: assert property (p_reset_load) else $error("nonvolatile byte not loaded");

  property p_scen_legal;
    (state == FSP_ST_RUN) ##1 (state == FSP_ST_RUN)
      |-> SCEN_ALLOWED[{$past(prot.pol), $past(prot.hdis), $past(prot.ldis),
                        prot.pol, prot.hdis, prot.ldis}];
  endproperty
  a_scen_legal: assert property (p_scen_legal) else $error("illegal scenario transition");

  property p_mass_gate;
    take && (cmd_in.kind == FSP_CMD_MASS) && !all_open
      |=> cmd_reject && !cmd_launch ##0 protect_violation_flag;
  endproperty
  a_mass_gate: assert property (p_mass_gate) else $error("mass erase under protection");

  property p_mass_ok;
    take && (cmd_in.kind == FSP_CMD_MASS) && all_open |=> cmd_launch;
  endproperty
  a_mass_ok: assert property (p_mass_ok) else $error("open mass erase not launched");

  property p_full_protect;
    take && !prot.pol && prot.hdis && prot.ldis |=> cmd_reject;
  endproperty
  a_full_protect: assert property (p_full_protect) else $error("fully protected array accepted");

  property p_none_protect;
    take && all_open |=> cmd_launch;
  endproperty
  a_none_protect: assert property (p_none_protect) else $error("open array rejected");

  property p_flag_blocks;
    protect_violation_flag |-> !cmd_ready ##1 !cmd_launch;
  endproperty
  a_flag_blocks: assert property (p_flag_blocks) else $error("launch while violation set");

  property p_clear_one;
    protect_violation_flag && wr_stat && reg_wdata[BIT_VIOL] |=> !protect_violation_flag;
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("violation flag not cleared");

  property p_high_range;
    take && prot.pol && !prot.hdis && cmd_in.kind != FSP_CMD_MASS
      && cmd_in.addr >= high_start |=> cmd_reject;
  endproperty
  a_high_range: assert property (p_high_range) else $error("high range not protected");

  property p_rd_latency;
    reg_rd && (reg_addr == ADDR_PROTECT) |=> reg_rdata == $past(prot);
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("protection read back wrong");

  property p_stat_read;
    reg_rd && (reg_addr == ADDR_STATUS)
      |=> reg_rdata[BIT_VIOL] == $past(protect_violation_flag);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read back wrong");

  property p_zero_write;
    protect_violation_flag && wr_stat && !reg_wdata[BIT_VIOL] |=> protect_violation_flag;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write cleared flag");

  property p_low_range;
    take && prot.pol && !prot.ldis && cmd_in.kind != FSP_CMD_MASS && in_low |=> cmd_reject;
  endproperty
  a_low_range: assert property (p_low_range) else $error("low range not protected");

  property p_high_off;
    take && prot.pol && prot.hdis && prot.ldis && cmd_in.kind != FSP_CMD_MASS
      |=> cmd_launch;
  endproperty
  a_high_off: assert property (p_high_off) else $error("disabled range protected");

  property p_window_open;
    take && !prot.pol && !prot.hdis && cmd_in.kind != FSP_CMD_MASS && in_high
      |=> cmd_launch;
  endproperty
  a_window_open: assert property (p_window_open) else $error("open window rejected");

  property p_outside_windows;
    take && !prot.pol && !prot.hdis && !prot.ldis && cmd_in.kind != FSP_CMD_MASS
      && !in_high && !in_low |=> cmd_reject;
  endproperty
  a_outside_windows: assert property (p_outside_windows) else $error("outside window taken");

  property p_one_result;
    !(cmd_launch && cmd_reject);
  endproperty
  a_one_result: assert property (p_one_result) else $error("launch and reject together");

  property p_cmd_copy;
    take |=> cmd_out == $past(cmd_in);
  endproperty
  a_cmd_copy: assert property (p_cmd_copy) else $error("command not captured");

  property p_spare_kept;
    (state == FSP_ST_RUN) ##1 (state == FSP_ST_RUN) |-> prot.spare == $past(prot.spare);
  endproperty
  a_spare_kept: assert property (p_spare_kept) else $error("spare bit written");

  c_reject: cover property (take && blocked ##1 cmd_reject);
  c_launch: cover property (take && !blocked ##1 cmd_launch);
  c_write_ignored: cover property (wr_prot && !write_ok);
  c_clear_flag: cover property (protect_violation_flag ##1 !protect_violation_flag);

endmodule
`default_nettype wire

// ### verif/fsp_flash_protect_test.sv
// self-checking testbench for the flash protection block
`default_nettype none
module fsp_flash_protect_test
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk          = 1'b0;
  logic              srst         = 1'b1;
  logic [BUS_AW-1:0] reg_addr     = '0;
  logic [7:0]        reg_wdata    = '0;
  logic              reg_wr       = 1'b0;
  logic              reg_rd       = 1'b0;
  logic [7:0]        reg_rdata;
  logic [7:0]        nv_prot_byte = 8'hFF;
  logic              cmd_valid    = 1'b0;
  fsp_cmd_t          cmd_in       = '0;
  logic              cmd_ready;
  logic              cmd_launch;
  logic              cmd_reject;
  fsp_cmd_t          cmd_out;
  logic              protect_violation_flag;
  int                n_mismatch   = 0;
  int                num_checks   = 0;

  fsp_flash_protect u_dut (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nv_prot_byte(nv_prot_byte),
    .cmd_valid(cmd_valid), .cmd_in(cmd_in), .cmd_ready(cmd_ready), .cmd_launch(cmd_launch),
    .cmd_reject(cmd_reject), .cmd_out(cmd_out),
    .protect_violation_flag(protect_violation_flag)
  );

  always #4 clk = ~clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic do_reset(input logic [7:0] nv);
    @(posedge clk);
    srst <= 1'b1;
    nv_prot_byte <= nv;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // expected protection of a command under register value p
  function automatic logic is_prot(input logic [7:0] p, input fsp_kind_t k, input logic [15:0] a);
    logic [15:0] hs;
    logic [15:0] le;
    logic        hit;
    hs = p[4] ? (p[3] ? 16'hC000 : 16'hE000) : (p[3] ? 16'hF000 : 16'hF800);
    le = p[1] ? (p[0] ? 16'h4FFF : 16'h47FF) : (p[0] ? 16'h43FF : 16'h41FF);
    hit = (!p[5] && a >= hs) || (!p[2] && a >= 16'h4000 && a <= le);
    if (k == FSP_CMD_MASS) return !(p[7] && p[5] && p[2]);
    return p[7] ? hit : !hit;
  endfunction

  task automatic run_cmd(input fsp_kind_t k, input logic [15:0] a, input logic rej);
    fsp_cmd_t   c;
    logic [7:0] st;
    c = '{kind: k, addr: a};
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_in <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk(cmd_launch, !rej, "launch");
    chk(cmd_reject, rej, "reject");
    chk(cmd_out, c, "command copy");
    chk(protect_violation_flag, rej, "violation flag");
    if (rej) begin
      chk(cmd_ready, 1'b0, "ready while flagged");
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_in <= fsp_cmd_t'(~c);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, st);
      chk(st[BIT_VIOL], 1'b1, "flag after zero write");
      chk(cmd_out, c, "nothing taken while flagged");
      @(posedge clk);
      cmd_valid <= 1'b0;
      wr(ADDR_STATUS, 8'h20);
      #1 chk(protect_violation_flag, 1'b0, "flag cleared");
    end
  endtask

  task automatic t_load();
    logic [7:0] d;
    do_reset(8'hFF);
    rd(ADDR_PROTECT, d);
    chk(d, 8'hFF, "reset load");
    @(posedge clk);
    #1 chk(reg_rdata, 8'h00, "read data after its cycle");
    rd(8'h10, d);
    chk(d, 8'h00, "unmapped read");
    run_cmd(FSP_CMD_MASS, 16'h0000, 1'b0);
  endtask

  task automatic t_trans();
    logic [7:0] ok [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
    logic [7:0] fb;
    logic [7:0] tb;
    logic [7:0] d;
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        fb = {f[2], 1'b0, f[1], 2'b00, f[0], 2'b00};
        tb = {t[2], 1'b0, t[1], 2'b00, t[0], 2'b00};
        do_reset(fb);
        wr(ADDR_PROTECT, tb);
        rd(ADDR_PROTECT, d);
        chk(d, ok[f][t] ? tb : fb, "scenario transition");
      end
    end
  endtask

  task automatic t_size();
    logic [7:0] d;
    do_reset(8'hA4);
    run_cmd(FSP_CMD_PROGRAM, NV_PROT_ADDR, 1'b0);
    wr(ADDR_PROTECT, 8'hBF);
    rd(ADDR_PROTECT, d);
    chk(d, 8'hBF, "sizes open");
    wr(ADDR_PROTECT, 8'h80);
    rd(ADDR_PROTECT, d);
    chk(d, 8'h80, "sizes with disables cleared");
    wr(ADDR_PROTECT, 8'h9B);
    rd(ADDR_PROTECT, d);
    chk(d, 8'h80, "sizes frozen");
    run_cmd(FSP_CMD_PROGRAM, NV_PROT_ADDR, 1'b1);
  endtask

  task automatic t_decode();
    logic [15:0] ad [18] = '{16'hF7FF, 16'hF800, 16'hEFFF, 16'hF000, 16'hDFFF, 16'hE000,
                             16'hBFFF, 16'hC000, 16'h41FF, 16'h4200, 16'h43FF, 16'h4400,
                             16'h47FF, 16'h4800, 16'h4FFF, 16'h5000, 16'h3FFF, 16'h4000};
    logic [7:0]  p;
    fsp_kind_t   k;
    for (int c = 0; c < 32; c++) begin
      p = {c[2], 1'b0, c[1], c[4:3], c[0], ~c[4:3]};
      do_reset(p);
      for (int i = 0; i < 18; i++) begin
        k = i[0] ? FSP_CMD_ERASE : FSP_CMD_PROGRAM;
        run_cmd(k, ad[i], is_prot(p, k, ad[i]));
      end
      run_cmd(FSP_CMD_MASS, 16'h8000, is_prot(p, FSP_CMD_MASS, 16'h8000));
    end
  endtask

  initial begin
    #400000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    t_load();
    t_trans();
    t_size();
    t_decode();
    summarize();
  end
endmodule
`default_nettype wire
